// ==== logic/keyboard_serial_port.sv ====
/*
 Keyboard serial port: receives and sends 11-bit frames over the open-drain
 keyboard clock and data lines, with clock-inhibit and transmit clock source
 controls taken as plain inputs.
 Assumes the pins arrive unsynchronised, the keyboard supplies every clock
 edge, and the pad logic resolves each line from the output enables.
*/
// Summary of operation
// [RL1] receiver turns frames into bytes, optional parity
// [RL2] transmitter adds start, parity and stop bits
// [RL3] clock inhibit pulls keyboard clock line low; ignored in ST_TX_SHIFT and ST_TX_ACK
// [RL4] source select gates keyboard clock to transmitter
// [RL5] lines only pulled low, never driven high
// [RL6] idle: both lines released and resting high
// [RL7] send: data low first, then release clock
// [RL8] keyboard makes all clock transitions
// [RL9] line pair states mean permit, inhibit, request, receive
// [RL10] software spaces register accesses apart
// [RL11] frame: start, eight data lsb first, odd parity, stop
// [RL12] flag processor when received byte is waiting
// [RL13] synchronise keyboard clock, sample on clean edges
`timescale 1ns/1ps
`include "kbd_link_defines.svh"

module keyboard_serial_port #(
	parameter int unsigned TX_INHIBIT_CYC = `TX_INHIBIT_US * `SYS_CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic kbd_clk_in,
	output logic kbd_clk_out,
	output logic kbd_clk_oe,
	input wire logic kbd_data_in,
	output logic kbd_data_out,
	output logic kbd_data_oe,
	input wire logic clock_inhibit,
	input wire logic transmit_clock_source_select,
	input wire logic parity_check_en,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	output logic tx_ready,
	output kbd_link_pkg::rx_word_t rx_word,
	output logic rx_valid,
	output logic serial_transmit_clock_input
);
	import kbd_link_pkg::*;

	localparam int unsigned RTS_CYC = (`RTS_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000;
	localparam logic [`CNT_W-1:0] HOLD_LAST = `CNT_W'(TX_INHIBIT_CYC - 1);
	localparam logic [`CNT_W-1:0] RTS_LAST = `CNT_W'(RTS_CYC - 1);

	core_t r;
	core_t nxt;
	logic clk_fall;
	logic dat_s;
	logic [9:0] rx_sh;

	// clean edge of the synchronised keyboard clock
	assign clk_fall = r.clk_sy[2] & ~r.clk_sy[1]; // RL13
	assign dat_s = r.dat_sy[1];
	assign rx_sh = {dat_s, r.sh[9:1]}; // RL11

	// next-state logic of the whole port
	always_comb
	begin
		nxt = r;
		nxt.clk_sy = {r.clk_sy[1:0], kbd_clk_in}; // RL13
		nxt.dat_sy = {r.dat_sy[0], kbd_data_in};
		nxt.rx_valid = 1'b0;
		nxt.stxc = transmit_clock_source_select ? r.clk_sy[2] : 1'b1; // RL4
		unique case (r.st)
			ST_IDLE:
			begin
				nxt.clk_oe = clock_inhibit; // RL3 RL9
				nxt.data_oe = 1'b0; // RL6
				if (tx_valid && r.tx_ready)
				begin
					nxt.st = ST_TX_HOLD;
					nxt.cnt = '0;
					nxt.clk_oe = 1'b1;
					nxt.tx_ready = 1'b0;
					nxt.sh = {1'b1, ~^tx_byte, tx_byte}; // RL2 RL11
				end
				else if (clk_fall && !dat_s && !clock_inhibit)
				begin
					nxt.st = ST_RX; // start bit seen
					nxt.bits = '0;
					nxt.tx_ready = 1'b0;
				end
			end
			ST_RX:
			begin
				nxt.clk_oe = clock_inhibit; // RL3
				if (clock_inhibit)
				begin
					nxt.st = ST_IDLE; // frame abandoned
					nxt.tx_ready = 1'b1;
				end
				else if (clk_fall)
				begin
					nxt.sh = rx_sh; // RL1
					nxt.bits = r.bits + 4'h1;
					if (r.bits == `FRAME_LAST_IDX)
					begin
						nxt.st = ST_IDLE;
						nxt.tx_ready = 1'b1;
						nxt.rx.data = rx_sh[7:0];
						nxt.rx.parity_err = parity_check_en & ~(^rx_sh[8:0]); // RL1
						nxt.rx.frame_err = ~rx_sh[9];
						nxt.rx_valid = 1'b1; // RL12
					end
				end
			end
			ST_TX_HOLD:
			begin
				nxt.cnt = r.cnt + `CNT_W'(1);
				if (r.cnt == HOLD_LAST)
				begin
					nxt.st = ST_TX_RTS;
					nxt.cnt = '0;
					nxt.data_oe = 1'b1; // RL7
				end
			end
			ST_TX_RTS:
			begin
				nxt.cnt = r.cnt + `CNT_W'(1);
				if (r.cnt == RTS_LAST)
				begin
					nxt.st = ST_TX_SHIFT;
					nxt.clk_oe = 1'b0; // RL7
					nxt.bits = '0;
				end
			end
			ST_TX_SHIFT:
			begin
				if (clk_fall) // RL8
				begin
					nxt.data_oe = ~r.sh[0]; // RL2 RL5
					nxt.sh = {1'b1, r.sh[9:1]};
					nxt.bits = r.bits + 4'h1;
					if (r.bits == `FRAME_LAST_IDX)
						nxt.st = ST_TX_ACK;
				end
			end
			ST_TX_ACK:
			begin
				nxt.data_oe = 1'b0;
				if (clk_fall) // keyboard acknowledge bit
				begin
					nxt.st = ST_IDLE;
					nxt.tx_ready = 1'b1;
				end
			end
		endcase
	end

	// state register, frozen while clk_en is low unless rst_b is low
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.clk_sy <= 3'h7;
			r.dat_sy <= 2'h3;
			r.tx_ready <= 1'b1;
			r.stxc <= 1'b1;
		end
		else if (clk_en)
			r <= nxt;
	end

	// outputs straight from the state record, line drive values tied low
	assign kbd_clk_out = 1'b0; // RL5
	assign kbd_data_out = 1'b0; // RL5
	assign kbd_clk_oe = r.clk_oe;
	assign kbd_data_oe = r.data_oe;
	assign tx_ready = r.tx_ready;
	assign rx_word = r.rx;
	assign rx_valid = r.rx_valid;
	assign serial_transmit_clock_input = r.stxc;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence rts_begin_s;
		$rose(kbd_data_oe) && kbd_clk_oe;
	endsequence
	sequence rts_hold_s;
		(kbd_data_oe && kbd_clk_oe) [*8];
	endsequence

	idle_release_a: assert property (r.st == ST_IDLE |-> !kbd_data_oe) // RL6
		else $error("data line held in idle");
	inhibit_pull_a: assert property (clk_en && clock_inhibit && r.st == ST_IDLE // RL3
		|=> kbd_clk_oe)
		else $error("clock not pulled low under inhibit");
	rts_order_a: assert property (rts_begin_s |-> rts_hold_s) // RL7
		else $error("clock released too soon after send request");
	clock_release_a: assert property ($fell(kbd_clk_oe) && r.st == ST_TX_SHIFT // RL7
		|-> kbd_data_oe)
		else $error("clock released without data low");
	txc_source_a: assert property (clk_en && !transmit_clock_source_select // RL4
		|=> serial_transmit_clock_input)
		else $error("transmit clock not held off");
	rx_pulse_a: assert property (rx_valid && clk_en |=> !rx_valid) // RL12
		else $error("receive flag longer than one cycle");
	rx_parity_a: assert property (rx_valid |-> rx_word.parity_err == // RL1
		($past(parity_check_en) & ~(^r.sh[8:0])))
		else $error("parity result wrong");
	tx_accept_a: assert property (clk_en && tx_valid && tx_ready |=> !tx_ready // RL2
		##0 kbd_clk_oe)
		else $error("send not started on accept");
	no_drive_high_a: assert property (!kbd_clk_out && !kbd_data_out) // RL5
		else $error("line driven high");
	sync_edge_a: assert property (clk_fall && $past(clk_en) // RL13
		|-> $past(r.clk_sy[1]) && !r.clk_sy[1])
		else $error("edge not from synchronised stages");

endmodule : keyboard_serial_port

// ==== pkg/kbd_link_defines.svh ====
/*
 Offsets-free timing and frame constants for the keyboard serial port.
 Assumes the system clock runs at 250 MHz.
*/
`ifndef KBD_LINK_DEFINES_SVH
`define KBD_LINK_DEFINES_SVH

// system clock rate in MHz
`define SYS_CLK_MHZ 250
// clock line held low before the send request, in microseconds
`define TX_INHIBIT_US 100
// data held low with clock still low before clock release, in ns
`define RTS_SETUP_NS 200
// bits after the start bit: eight data, parity, stop
`define FRAME_TAIL_BITS 4'hA
// index of the last tail bit counted
`define FRAME_LAST_IDX 4'h9
// width of the cycle counter
`define CNT_W 15

`endif

// ==== pkg/kbd_link_pkg.sv ====
/*
 Types for the keyboard serial port: line state machine, received word and
 the packed state record of the core.
 Assumes kbd_link_defines.svh is on the include path.
*/
`include "kbd_link_defines.svh"

package kbd_link_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_TX_HOLD,
		ST_TX_RTS,
		ST_TX_SHIFT,
		ST_TX_ACK
	} link_state_t;

	// one received byte with its checks
	typedef struct packed {
		logic [7:0] data;
		logic parity_err;
		logic frame_err;
	} rx_word_t;

	// whole state of the core
	typedef struct packed {
		link_state_t st;
		logic [2:0] clk_sy;
		logic [1:0] dat_sy;
		logic [`CNT_W-1:0] cnt;
		logic [9:0] sh;
		logic [3:0] bits;
		logic clk_oe;
		logic data_oe;
		logic tx_ready;
		logic rx_valid;
		rx_word_t rx;
		logic stxc;
	} core_t;

endpackage : kbd_link_pkg

// ==== test/kbd_model.sv ====
/*
 keyboard model: makes every link clock edge, sends and takes frames.
 assumes the bench resolves both open-drain lines.
*/
`timescale 1ns/1ps
module kbd_model (
	input wire logic clk_line,
	input wire logic data_line,
	output logic clk_pull,
	output logic data_pull
);
	// both lines released while idle
	initial
	begin
		clk_pull = 1'b0;
		data_pull = 1'b0;
	end
	// send one frame, flip corrupts parity; stops if the host holds clock low
	task send(input logic [7:0] b, input logic flip);
		logic [10:0] f;
		f = {1'b1, ~^b ^ flip, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			data_pull = ~f[i];
			#24;
			if (clk_line !== 1'b1)
				break;
			clk_pull = 1'b1;
			#24 clk_pull = 1'b0;
		end
		data_pull = 1'b0;
	endtask : send
	// clock in ten bits, then acknowledge
	task recv(output logic [9:0] r);
		// leave the released clock high long enough for the host to see it
		#24;
		for (int i = 0; i < 10; i++)
		begin
			clk_pull = 1'b1;
			#24 r[i] = data_line;
			clk_pull = 1'b0;
			#24;
		end
		data_pull = 1'b1;
		clk_pull = 1'b1;
		#24 clk_pull = 1'b0;
		#24 data_pull = 1'b0;
	endtask : recv
endmodule : kbd_model

// ==== test/keyboard_serial_port_bench.sv ====
/*
 bench for the keyboard serial port: receive, send, inhibit, clock select.
 assumes kbd_model on the far side and a 4 ns system clock.
*/
`timescale 1ns/1ps
module keyboard_serial_port_bench;
	import kbd_link_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic inh = 1'b0;
	logic sel = 1'b0;
	logic par_en = 1'b1;
	logic [7:0] tx_byte = 8'h00;
	logic tx_valid = 1'b0;
	logic en = 1'b1;
	logic clk_o, data_o;
	logic clk_oe, data_oe, k_clk, k_dat, tx_ready, rx_valid, stxc;
	rx_word_t rx_word;
	wire logic clk_line = ~(clk_oe | k_clk);
	wire logic data_line = ~(data_oe | k_dat);
	int err_total = 0;
	int total_checks = 0;
	int n;
	// system clock
	always #2 sys_clk = ~sys_clk;
	keyboard_serial_port #(.TX_INHIBIT_CYC(20)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.clk_en(en), .kbd_clk_in(clk_line), .kbd_clk_out(clk_o), .kbd_clk_oe(clk_oe),
		.kbd_data_in(data_line), .kbd_data_out(data_o), .kbd_data_oe(data_oe),
		.clock_inhibit(inh), .transmit_clock_source_select(sel),
		.parity_check_en(par_en), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
		.serial_transmit_clock_input(stxc));
	kbd_model kbd (.clk_line(clk_line), .data_line(data_line), .clk_pull(k_clk),
		.data_pull(k_dat));
	task stop_test();
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	task give_up(input int lim);
		if (n >= lim)
		begin
			err_total++;
			$display("mismatch at %0t: wait ran out", $time);
			stop_test();
		end
	endtask : give_up
	// keyboard sends a frame, byte must arrive once
	task rx_frame(input logic [7:0] b, input logic flip);
		fork
			kbd.send(b, flip);
		join_none
		for (n = 0; n < 200 && rx_valid !== 1'b1; n++)
			tick();
		give_up(200);
		check(rx_word, {b, flip & par_en, 1'b0});
		tick();
		check(10'(rx_valid), 10'h000);
		#200;
	endtask : rx_frame
	// inhibit cuts a keyboard frame: nothing delivered, port back to idle
	task rx_cut();
		fork
			kbd.send(8'h5A, 1'b0);
		join_none
		repeat (60) tick();
		inh = 1'b1;
		tick();
		check({8'h00, tx_ready, clk_oe}, 10'h003);
		for (n = 0; n < 100 && rx_valid !== 1'b1; n++)
			tick();
		check(10'(n), 10'h064);
		inh = 1'b0;
		tick();
		check(10'(clk_oe), 10'h000);
	endtask : rx_cut
	// host sends a byte, keyboard clocks it in
	task tx_frame(input logic [7:0] b);
		logic [9:0] r;
		tx_byte = b;
		tx_valid = 1'b1;
		tick();
		tx_valid = 1'b0;
		check({7'h00, tx_ready, clk_oe, data_oe}, 10'h002);
		for (n = 0; n < 40 && data_oe !== 1'b1; n++)
			tick();
		give_up(40);
		check(10'(clk_oe), 10'h001);
		for (n = 0; n < 80 && clk_oe !== 1'b0; n++)
			tick();
		give_up(80);
		check(10'(data_oe), 10'h001);
		kbd.recv(r);
		check(r, {1'b1, ~^b, b});
		for (n = 0; n < 50 && tx_ready !== 1'b1; n++)
			tick();
		give_up(50);
		check({8'h00, clk_oe, data_oe}, 10'h000);
	endtask : tx_frame
	// inhibit and transmit clock source select
	task controls();
		en = 1'b0;
		sel = 1'b1;
		inh = 1'b1;
		repeat (2) tick();
		check(10'(clk_oe), 10'h000);
		en = 1'b1;
		tick();
		check(10'(clk_oe), 10'h001);
		repeat (6) tick();
		check(10'(stxc), 10'h000);
		sel = 1'b0;
		repeat (6) tick();
		check(10'(stxc), 10'h001);
		inh = 1'b0;
		tick();
		check(10'(clk_oe), 10'h000);
	endtask : controls
	// main sequence
	initial
	begin
		repeat (3) tick();
		rst_b = 1'b1;
		check({7'h00, clk_oe, data_oe, tx_ready}, 10'h001);
		check({8'h00, clk_o, data_o}, 10'h000);
		rx_frame(8'hA5, 1'b0);
		rx_frame(8'h3C, 1'b1);
		rx_cut();
		par_en = 1'b0;
		rx_frame(8'h81, 1'b1);
		tx_frame(8'hED);
		tx_frame(8'h00);
		controls();
		stop_test();
	end
endmodule : keyboard_serial_port_bench
